// file: design/tmi_chan_timer.sv
// one channel: counts monitoring ticks between start temperature adjustments
`timescale 1ns/100ps
`default_nettype none
module tmi_chan_timer
	import tmi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic enable,
	input wire logic [2:0] code,
	input wire logic adj_dn,
	input wire logic adj_up,
	output logic dn_ok,
	output logic up_ok
);
	logic [TMI_CNT_W-1:0] cnt_q, cnt_d;
	logic [TMI_CNT_W-1:0] dn_lim, up_lim;

	// limits 8<<n and 16<<n
	assign dn_lim = TMI_CNT_W'(TMI_DEC_BASE) << code;
	assign up_lim = TMI_CNT_W'(TMI_INC_BASE) << code;

	always_comb begin
		cnt_d = cnt_q;
		if (!enable || adj_dn || adj_up) begin
			cnt_d = '0;
		end else if (tick && cnt_q < up_lim) begin
			// a lowered code leaves the count parked above the new limit
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign dn_ok = enable && (cnt_q >= dn_lim);
	assign up_ok = enable && (cnt_q >= up_lim);

	count_bound_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		cnt_q >= up_lim |=> cnt_q == $past(cnt_q) || cnt_q == '0)
		else $error("count passed limit");
	restart_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(adj_dn || adj_up) |=> !dn_ok && !up_ok) else $error("no restart");
endmodule
`default_nettype wire

// file: design/tmi_interval_cfg.sv
// top: interval configuration register and per-channel adjustment pacing
// What this block does
// - register resets to 0x00, shortest interval on every channel while control reg 1 bit 0 (remote 2 code msb) is 0
// - lock bit set: writes to the register are ignored
// - bits 2:0 hold remote 1 interval code
// - bits 5:3 hold local interval code
// - bits 7:6 are remote 2 code low bits, msb from control reg 1
// - downward wait is 8 shifted left by code ticks
// - upward wait is twice the downward wait
// - monitoring tick runs eight times per second
// - control register 1 bit 0 gives remote 2 code msb
// - channel enable low: no adjustment allowed on that channel
`timescale 1ns/100ps
`default_nettype none
module tmi_interval_cfg
	import tmi_pkg::*;
#(
	parameter int TICK_DIV = TMI_TICK_DIV
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire tmi_wr_t WR,
	input wire logic [7:0] RD_ADDR,
	output logic [7:0] RD_DATA,
	input wire logic LOCK,
	input wire logic REMOTE2_CODE_MSB,
	input wire logic [2:0] DYNAMIC_ENABLE,
	input wire logic [2:0] ADJ_DN,
	input wire logic [2:0] ADJ_UP,
	output logic [2:0] DN_OK,
	output logic [2:0] UP_OK,
	output logic TICK
);
	// ----------------------------------------
	// register
	// ----------------------------------------
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] rd_q, rd_d;
	logic [2:0] code [TMI_NCH];

	always_comb begin
		cfg_d = cfg_q;
		// locked or foreign-address writes are dropped
		if (WR.we && WR.addr == TMI_CFG2_ADDR && !LOCK) begin
			cfg_d = WR.wdata;
		end
		rd_d = (RD_ADDR == TMI_CFG2_ADDR) ? cfg_q : 8'h00;
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_q <= TMI_CFG2_RESET;
			rd_q <= 8'h00;
		end else begin
			cfg_q <= cfg_d;
			rd_q <= rd_d;
		end
	end
	assign RD_DATA = rd_q;

	other_addr_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		!(WR.we && WR.addr == TMI_CFG2_ADDR) |=> $stable(cfg_q))
		else $error("register changed without a write");
	read_data_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		1'b1 |=> RD_DATA == (($past(RD_ADDR) == TMI_CFG2_ADDR) ?
		$past(cfg_q) : 8'h00)) else $error("read data wrong");

	// remote 2 code takes its msb from control register 1
	assign code[0] = cfg_q[TMI_R1_LSB +: 3];
	assign code[1] = cfg_q[TMI_LOC_LSB +: 3];
	assign code[2] = {REMOTE2_CODE_MSB, cfg_q[TMI_R2_LSB +: 2]};

	// ----------------------------------------
	// monitoring tick
	// ----------------------------------------
	logic [31:0] div_q, div_d;
	logic tick_q, tick_d;

	always_comb begin
		tick_d = 1'b0;
		div_d = div_q + 32'h1;
		if (div_q >= 32'(TICK_DIV - 1)) begin
			div_d = 32'h0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			div_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end
	assign TICK = tick_q;

	// ----------------------------------------
	// tick spacing check
	// ----------------------------------------
	// clocks since the last tick, helper for the checks only
	logic [31:0] gap_q, gap_d;
	logic seen_tick_q, seen_tick_d;

	always_comb begin
		gap_d = gap_q + 32'h1;
		seen_tick_d = seen_tick_q;
		if (tick_q) begin
			gap_d = 32'h0;
			seen_tick_d = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			gap_q <= 32'h0;
			seen_tick_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			seen_tick_q <= seen_tick_d;
		end
	end

	tick_period_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		(tick_q && seen_tick_q) |-> gap_q == 32'(TICK_DIV - 1))
		else $error("tick period wrong");
	tick_late_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		seen_tick_q |-> gap_q < 32'(TICK_DIV))
		else $error("tick missing");

	// ----------------------------------------
	// channel timers
	// ----------------------------------------
	for (genvar i = 0; i < TMI_NCH; i++) begin : g_ch
		tmi_chan_timer u_tmr (
			.clk(MCLK),
			.rst_b(RST_B),
			.tick(tick_q),
			.enable(DYNAMIC_ENABLE[i]),
			.code(code[i]),
			.adj_dn(ADJ_DN[i]),
			.adj_up(ADJ_UP[i]),
			.dn_ok(DN_OK[i]),
			.up_ok(UP_OK[i])
		);
	end

	// ----------------------------------------
	// per-channel interval checks
	// ----------------------------------------
	// own tick count per channel, cleared like the timer but never
	// parked below the longest wait, so it bounds the timer from above
	for (genvar i = 0; i < TMI_NCH; i++) begin : g_chk
		logic [TMI_CNT_W-1:0] dn_min, up_min;
		logic [TMI_CNT_W-1:0] ref_q, ref_d;

		assign dn_min = TMI_CNT_W'(TMI_DEC_BASE) << code[i];
		assign up_min = dn_min << 1;

		always_comb begin
			ref_d = ref_q;
			if (!DYNAMIC_ENABLE[i] || ADJ_DN[i] || ADJ_UP[i]) begin
				ref_d = '0;
			end else if (tick_q && ref_q != '1) begin
				ref_d = ref_q + 1'b1;
			end
		end

		always_ff @(posedge MCLK or negedge RST_B) begin
			if (!RST_B) begin
				ref_q <= '0;
			end else begin
				ref_q <= ref_d;
			end
		end

		early_dn_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			DN_OK[i] |-> ref_q >= dn_min)
			else $error("downward allowed too early");
		early_up_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			UP_OK[i] |-> ref_q >= up_min)
			else $error("upward allowed too early");
		up_after_dn_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			UP_OK[i] |-> DN_OK[i])
			else $error("upward before downward");
		up_restart_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			ADJ_UP[i] |=> !UP_OK[i] && !DN_OK[i])
			else $error("no restart after upward step");
		dn_hold_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			(DN_OK[i] && !ADJ_DN[i] && !ADJ_UP[i]) |=> DN_OK[i] ||
			!DYNAMIC_ENABLE[i] || $changed(code[i])) else $error("ok lost");
		reenable_a: assert property (
			@(posedge MCLK) disable iff (!RST_B)
			(!DYNAMIC_ENABLE[i] ##1 DYNAMIC_ENABLE[i]) |-> !DN_OK[i])
			else $error("stale count after enable");
	end

	lock_hold_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		LOCK |=> $stable(cfg_q)) else $error("locked register changed");
	write_take_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		(WR.we && WR.addr == TMI_CFG2_ADDR && !LOCK) |=>
		cfg_q == $past(WR.wdata)) else $error("write lost");
	enable_gate_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		(DN_OK | UP_OK) == ((DN_OK | UP_OK) & DYNAMIC_ENABLE))
		else $error("disabled channel allowed");
	tick_space_a: assert property (
		@(posedge MCLK) disable iff (!RST_B)
		TICK |=> !TICK) else $error("tick too dense");
endmodule
`default_nettype wire

// file: shared/tmi_pkg.sv
// package: register map, field layout and interval timing for fan_start_temperature interval config
package tmi_pkg;
	localparam logic [7:0] TMI_CFG2_ADDR = 8'h8f;
	localparam logic [7:0] TMI_CFG2_RESET = 8'h00;
	localparam int TMI_R1_LSB = 0;
	localparam int TMI_LOC_LSB = 3;
	localparam int TMI_R2_LSB = 6;
	localparam int TMI_NCH = 3;
	localparam int TMI_DEC_BASE = 8;
	localparam int TMI_INC_BASE = 16;
	localparam int TMI_CNT_W = 12;
	localparam int TMI_TICKS_PER_SEC = 8;
	localparam int TMI_CLK_HZ = 200000000;
	localparam int TMI_TICK_DIV = TMI_CLK_HZ / TMI_TICKS_PER_SEC;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmi_wr_t;

	typedef enum logic [2:0] {
		TMI_ST_IDLE = 3'b001,
		TMI_ST_WAIT = 3'b010,
		TMI_ST_READY = 3'b100
	} tmi_state_t;
endpackage

// file: tb/tmi_interval_cfg_bench.sv
// bench for the interval configuration register
`timescale 1ns/100ps
`default_nettype none
module tmi_interval_cfg_bench;
	import tmi_pkg::*;
	logic MCLK = 0;
	logic RST_B = 0;
	tmi_wr_t WR = '0;
	logic [7:0] RD_ADDR = 8'h00;
	logic [7:0] RD_DATA;
	logic LOCK = 0;
	logic REMOTE2_CODE_MSB = 0;
	logic [2:0] DYNAMIC_ENABLE = 3'h7;
	logic [2:0] ADJ_DN = 3'h0;
	logic [2:0] ADJ_UP = 3'h0;
	logic [2:0] DN_OK, UP_OK;
	logic TICK;
	int fail_count = 0;
	int n_tests = 0;
	int dn[3], up[3], t;
	always #2.5 MCLK = ~MCLK;
	tmi_interval_cfg #(.TICK_DIV(4)) i_tmi_interval_cfg (.MCLK(MCLK),
		.RST_B(RST_B), .WR(WR), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
		.LOCK(LOCK), .REMOTE2_CODE_MSB(REMOTE2_CODE_MSB),
		.DYNAMIC_ENABLE(DYNAMIC_ENABLE), .ADJ_DN(ADJ_DN), .ADJ_UP(ADJ_UP),
		.DN_OK(DN_OK), .UP_OK(UP_OK), .TICK(TICK));
	// ----
	// tasks
	// ----
	task check(input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge MCLK) WR = {1'b1, a, d};
		@(negedge MCLK) WR = '0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge MCLK) RD_ADDR = a;
		@(negedge MCLK) check(RD_DATA, e);
	endtask
	task t_fields;
		rd(8'h8f, 8'h00);
		wr(8'h8f, 8'hc5);
		rd(8'h8f, 8'hc5);
		wr(8'h90, 8'hff);
		rd(8'h90, 8'h00);
		LOCK = 1;
		wr(8'h8f, 8'h3a);
		rd(8'h8f, 8'hc5);
		LOCK = 0;
		$display("fields and lock test done");
	endtask
	task t_pace;
		wr(8'h8f, 8'h08);
		REMOTE2_CODE_MSB = 1;
		dn = '{0, 0, 0};
		up = '{0, 0, 0};
		t = 0;
		@(negedge MCLK) ADJ_DN = 3'h7;
		repeat (1100) begin
			@(negedge MCLK);
			ADJ_DN = 3'h0;
			for (int i = 0; i < 3; i++) begin
				if (DN_OK[i] === 1'b1 && dn[i] == 0) dn[i] = t;
				if (UP_OK[i] === 1'b1 && up[i] == 0) up[i] = t;
			end
			if (TICK === 1'b1) t++;
		end
		check(12'(dn[0]), 12'd8);
		check(12'(up[0]), 12'd16);
		check(12'(dn[1]), 12'd16);
		check(12'(up[1]), 12'd32);
		check(12'(dn[2]), 12'd128);
		check(12'(up[2]), 12'd256);
		check(12'(t), 12'd275);
		$display("pacing test done");
	endtask
	task t_enable;
		wr(8'h8f, 8'h00);
		check(12'(UP_OK), 12'h007);
		@(negedge MCLK) DYNAMIC_ENABLE = 3'h6;
		@(negedge MCLK);
		@(negedge MCLK) check(12'(DN_OK), 12'h006);
		check(12'(UP_OK), 12'h006);
		@(negedge MCLK) ADJ_UP = 3'h4;
		@(negedge MCLK) ADJ_UP = 3'h0;
		check(12'(DN_OK), 12'h002);
		check(12'(UP_OK), 12'h002);
		@(negedge MCLK) DYNAMIC_ENABLE = 3'h7;
		@(negedge MCLK) check(12'(DN_OK), 12'h002);
		$display("enable test done");
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#50000;
		fail_count++;
		close_out();
	end
	initial begin
		repeat (5) @(negedge MCLK);
		RST_B = 1;
		t_fields();
		t_pace();
		t_enable();
		close_out();
	end
endmodule
`default_nettype wire
